/* File: verilog/tmw_pkg.sv */
/*
  tmw_pkg: shared constants and carriers for the 16-bit timer block.
  assumes an 8-bit register port with one-cycle strobes and a single clock.
*/
package tmw_pkg;
  // register offsets on the 8-bit register port
  localparam logic [4:0] ADDR_CTRL_A = 5'h00;
  localparam logic [4:0] ADDR_CTRL_B = 5'h01;
  localparam logic [4:0] ADDR_CTRL_C = 5'h02;
  localparam logic [4:0] ADDR_FLAG = 5'h03;
  localparam logic [4:0] ADDR_MASK = 5'h04;
  localparam logic [4:0] ADDR_CNT_L = 5'h08;
  localparam logic [4:0] ADDR_CNT_H = 5'h09;
  localparam logic [4:0] ADDR_CAP_L = 5'h0a;
  localparam logic [4:0] ADDR_CAP_H = 5'h0b;
  localparam logic [4:0] ADDR_CMPA_L = 5'h0c;
  localparam logic [4:0] ADDR_CMPA_H = 5'h0d;
  localparam logic [4:0] ADDR_CMPB_L = 5'h0e;
  localparam logic [4:0] ADDR_CMPB_H = 5'h0f;
  // field positions
  localparam int CS_LSB = 0;
  localparam int WGM2_POS = 3;
  localparam int WGM3_POS = 4;
  localparam int CAP_EDGE_POS = 6;
  localparam int NOISE_POS = 7;
  localparam int FOCB_POS = 6;
  localparam int FOCA_POS = 7;
  localparam int FLG_OVF = 0;
  localparam int FLG_CMPA = 1;
  localparam int FLG_CMPB = 2;
  localparam int FLG_CAP = 5;
  // reset values and fixed counter points
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam int NOISE_SAMPLES = 4;
  // clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // register port request
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmw_req_s;
endpackage

/* File: verilog/tmw_tick_gen.sv */
/*
  tmw_tick_gen: clock select, prescaler taps and external pin edge detection.
  assumes the external pin is already synchronous to sys_clk_i.
*/
`timescale 1ns/1ps
module tmw_tick_gen (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // control
  input wire logic [2:0] clk_sel_i,
  input wire logic ext_count_pin_i,
  // tick out
  output logic timer_tick_o
);
  import tmw_pkg::*;

  logic [9:0] pre; // free running prescaler
  logic [9:0] next_pre;
  logic pin_d; // last pin sample for edge detect
  logic tick;
  logic next_tick;

  // pick the tick source; stop code yields no ticks at all
  always_comb begin
    next_pre = pre + 10'h001;
    next_tick = 1'b0;
    case (clk_sel_i)
      3'h1: next_tick = 1'b1;
      3'h2: next_tick = (pre[2:0] == 3'h7);
      3'h3: next_tick = (pre[5:0] == 6'h3f);
      3'h4: next_tick = (pre[7:0] == 8'hff);
      3'h5: next_tick = (pre == 10'h3ff);
      CS_EXT_FALL: next_tick = pin_d & ~ext_count_pin_i;
      CS_EXT_RISE: next_tick = ~pin_d & ext_count_pin_i;
      default: next_tick = 1'b0;
    endcase
  end

  // register prescaler, pin sample and tick
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre <= 10'h000;
      pin_d <= 1'b0;
      tick <= 1'b0;
    end else begin
      pre <= next_pre;
      pin_d <= ext_count_pin_i;
      tick <= next_tick;
    end
  end

  assign timer_tick_o = tick;
endmodule

/* File: verilog/tmw_cap_filter.sv */
/*
  tmw_cap_filter: optional noise filter and edge detector for the capture trigger.
  assumes the trigger input is synchronous to sys_clk_i.
*/
`timescale 1ns/1ps
module tmw_cap_filter (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // control
  input wire logic filt_en_i,
  input wire logic rise_i,
  input wire logic trig_i,
  // event
  output logic event_o
);
  import tmw_pkg::*;

  logic [NOISE_SAMPLES-1:0] hist; // recent samples
  logic [NOISE_SAMPLES-1:0] next_hist;
  logic level; // filtered level
  logic next_level;
  logic evt;
  logic next_evt;

  // filter needs all samples equal before the level moves
  always_comb begin
    next_hist = {hist[NOISE_SAMPLES-2:0], trig_i};
    next_level = level;
    if (!filt_en_i) begin
      next_level = trig_i;
    end else if (&hist) begin
      next_level = 1'b1;
    end else if (~|hist) begin
      next_level = 1'b0;
    end
    next_evt = rise_i ? (next_level & ~level) : (~next_level & level);
  end

  // register filter state
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hist <= '0;
      level <= 1'b0;
      evt <= 1'b0;
    end else begin
      hist <= next_hist;
      level <= next_level;
      evt <= next_evt;
    end
  end

  assign event_o = evt;
endmodule

/* File: verilog/tmw_timer16.sv */
/*
  tmw_timer16: 16-bit timer with byte-wide register access through one
  shared high-byte holding register, two buffered compares and a capture.
  assumes a register master with one-cycle strobes and inputs synchronous
  to sys_clk_i; the power-off bit is held outside and arrives as a level.
*/
// What this block does
// - 16-bit data registers, direct 8-bit controls
// - every request flagged and individually masked
// - clock select internal or pin edge; stop
// - buffered compares matched continuously, set flags
// - capture latches count on filtered edge event
// - top from fixed values, compare A, capture
// - compare A as top: no pwm, buffered except in mode 4
// - bottom at zero, max at all ones
// - one shared 8-bit high-byte holding register
// - only low-byte access moves 16 bits
// - low write loads holding and low together
// - counter and capture low reads copy high into holding
// - compare high reads bypass holding register
// - low mode bits keep legacy positions
// - force bits in ctrl c, mode3 in b
// - high-byte location maps to holding register
// - counter write beats clear and count
`timescale 1ns/1ps
module tmw_timer16 (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // register port
  input wire tmw_pkg::tmw_req_s req_i,
  output logic [7:0] rdata_o,
  // pins and power
  input wire logic timer_power_off_bit_i,
  input wire logic ext_count_pin_i,
  input wire logic capture_pin_i,
  input wire logic comparator_i,
  input wire logic cap_from_comp_i,
  // outputs
  output logic wave_out_a_o,
  output logic wave_out_b_o,
  output logic irq_o
);
  import tmw_pkg::*;

  logic [7:0] ctrl_reg_a; // mode bits 1:0 in legacy pwm positions
  logic [7:0] ctrl_reg_b; // clock select, mode bits 3:2, capture options
  logic [7:0] timer_flag_reg;
  logic [7:0] timer_mask_reg;
  logic [15:0] count_value;
  logic [15:0] compare_reg_a; // buffer written by software
  logic [15:0] compare_reg_b;
  logic [15:0] cmp_a_act; // active copies used by the comparator
  logic [15:0] cmp_b_act;
  logic [15:0] capture_reg;
  logic [7:0] hold_hi; // shared high-byte holding register
  logic [7:0] rdata;
  logic wave_a;
  logic wave_b;
  logic irq;
  logic [7:0] next_ctrl_a, next_ctrl_b, next_flag, next_mask, next_hold, next_rdata;
  logic [15:0] next_count, next_cmpa, next_cmpb, next_cmpa_act, next_cmpb_act;
  logic [15:0] next_cap;
  logic next_wave_a, next_wave_b, next_irq;
  logic tick, cap_evt, run;
  logic [3:0] mode;
  logic [15:0] top;
  logic at_top, at_bottom, at_max, match_a, match_b;

  // decode a byte access: true when strobe hits address
  function automatic logic hit(input logic strobe, input logic [4:0] a, input logic [4:0] t);
    return strobe && (a == t);
  endfunction

  // waveform mode: bits 1:0 from ctrl a, bits 3:2 from ctrl b
  assign mode = {ctrl_reg_b[WGM3_POS], ctrl_reg_b[WGM2_POS], ctrl_reg_a[1:0]};
  assign run = ~timer_power_off_bit_i;

  tmw_tick_gen u_tick (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .clk_sel_i(run ? ctrl_reg_b[CS_LSB +: 3] : CS_STOP),
    .ext_count_pin_i(ext_count_pin_i),
    .timer_tick_o(tick)
  );

  tmw_cap_filter u_cap (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .filt_en_i(ctrl_reg_b[NOISE_POS]),
    .rise_i(ctrl_reg_b[CAP_EDGE_POS]),
    .trig_i(cap_from_comp_i ? comparator_i : capture_pin_i),
    .event_o(cap_evt)
  );

  // top selection by mode
  always_comb begin
    case (mode)
      4'h1, 4'h5: top = TOP_8BIT;
      4'h2, 4'h6: top = TOP_9BIT;
      4'h3, 4'h7: top = TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: top = cmp_a_act;
      4'h8, 4'ha, 4'hc, 4'he: top = capture_reg;
      default: top = CNT_MAX;
    endcase
  end

  assign at_top = (count_value == top);
  assign at_bottom = (count_value == CNT_BOTTOM);
  assign at_max = (count_value == CNT_MAX);
  assign match_a = (count_value == cmp_a_act);
  assign match_b = (count_value == cmp_b_act);

  // registers, counter, byte access and flags
  always_comb begin
    next_ctrl_a = ctrl_reg_a;
    next_ctrl_b = ctrl_reg_b;
    next_mask = timer_mask_reg;
    next_flag = timer_flag_reg;
    next_hold = hold_hi;
    next_cmpa = compare_reg_a;
    next_cmpb = compare_reg_b;
    next_cmpa_act = cmp_a_act;
    next_cmpb_act = cmp_b_act;
    next_cap = capture_reg;
    next_count = count_value;
    next_wave_a = wave_a;
    next_wave_b = wave_b;
    next_rdata = 8'h00;
    // flag clear by writing one comes first, so any event set below wins
    if (hit(req_i.wr, req_i.addr, ADDR_FLAG)) begin
      next_flag = timer_flag_reg & ~req_i.wdata;
    end
    // counting: up with wrap at top; compare copies refresh at top
    if (tick) begin
      if (at_top) begin
        next_count = CNT_BOTTOM;
        next_cmpa_act = compare_reg_a;
        next_cmpb_act = compare_reg_b;
        next_flag[FLG_OVF] = 1'b1;
      end else begin
        next_count = count_value + 16'h0001;
      end
    end
    // non-pwm modes take new compare values at once
    if (mode == 4'h0 || mode == 4'h4 || mode == 4'hc) begin
      next_cmpa_act = compare_reg_a;
      next_cmpb_act = compare_reg_b;
    end
    // compare matches while counting, or forced by software
    if (tick && match_a) begin
      next_flag[FLG_CMPA] = 1'b1;
      next_wave_a = (top == cmp_a_act && mode[0]) ? 1'b0 : ~wave_a;
    end
    if (tick && match_b) begin
      next_flag[FLG_CMPB] = 1'b1;
      next_wave_b = ~wave_b;
    end
    if (hit(req_i.wr, req_i.addr, ADDR_CTRL_C)) begin
      if (req_i.wdata[FOCA_POS]) next_wave_a = ~wave_a;
      if (req_i.wdata[FOCB_POS]) next_wave_b = ~wave_b;
    end
    // capture latches the live count
    if (cap_evt) begin
      next_cap = count_value;
      next_flag[FLG_CAP] = 1'b1;
    end
    // control registers: plain 8-bit access
    if (hit(req_i.wr, req_i.addr, ADDR_CTRL_A)) next_ctrl_a = req_i.wdata;
    if (hit(req_i.wr, req_i.addr, ADDR_CTRL_B)) next_ctrl_b = req_i.wdata;
    if (hit(req_i.wr, req_i.addr, ADDR_MASK)) next_mask = req_i.wdata;
    // high-byte writes only fill the holding register
    if (req_i.wr && (req_i.addr == ADDR_CNT_H || req_i.addr == ADDR_CAP_H ||
        req_i.addr == ADDR_CMPA_H || req_i.addr == ADDR_CMPB_H)) begin
      next_hold = req_i.wdata;
    end
    // low-byte writes move all 16 bits at once
    if (hit(req_i.wr, req_i.addr, ADDR_CNT_L)) next_count = {hold_hi, req_i.wdata};
    if (hit(req_i.wr, req_i.addr, ADDR_CMPA_L)) next_cmpa = {hold_hi, req_i.wdata};
    if (hit(req_i.wr, req_i.addr, ADDR_CMPB_L)) next_cmpb = {hold_hi, req_i.wdata};
    // capture is top only in modes 8, a, c and e; elsewhere the write is dropped
    if (hit(req_i.wr, req_i.addr, ADDR_CAP_L) && mode[3] && !mode[0]) begin
      next_cap = {hold_hi, req_i.wdata};
    end
    // reads: data one cycle later from rdata
    if (req_i.rd) begin
      if (req_i.addr == ADDR_CTRL_A) begin
        next_rdata = ctrl_reg_a;
      end else if (req_i.addr == ADDR_CTRL_B) begin
        next_rdata = ctrl_reg_b;
      end else if (req_i.addr == ADDR_FLAG) begin
        next_rdata = timer_flag_reg;
      end else if (req_i.addr == ADDR_MASK) begin
        next_rdata = timer_mask_reg;
      end else if (req_i.addr == ADDR_CNT_L) begin
        next_rdata = count_value[7:0];
        next_hold = count_value[15:8];
      end else if (req_i.addr == ADDR_CAP_L) begin
        next_rdata = capture_reg[7:0];
        next_hold = capture_reg[15:8];
      end else if (req_i.addr == ADDR_CMPA_L) begin
        next_rdata = compare_reg_a[7:0];
      end else if (req_i.addr == ADDR_CMPB_L) begin
        next_rdata = compare_reg_b[7:0];
      end else if (req_i.addr == ADDR_CMPA_H) begin
        next_rdata = compare_reg_a[15:8];
      end else if (req_i.addr == ADDR_CMPB_H) begin
        next_rdata = compare_reg_b[15:8];
      end else if (req_i.addr == ADDR_CNT_H || req_i.addr == ADDR_CAP_H) begin
        next_rdata = hold_hi;
      end else begin
        next_rdata = 8'h00; // unmapped and ctrl c read as zero
      end
    end
    next_irq = |(next_flag & next_mask);
  end

  // register everything
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg_a <= CTRL_RST;
      ctrl_reg_b <= CTRL_RST;
      timer_flag_reg <= CTRL_RST;
      timer_mask_reg <= CTRL_RST;
      hold_hi <= CTRL_RST;
      count_value <= CNT_BOTTOM;
      compare_reg_a <= CNT_BOTTOM;
      compare_reg_b <= CNT_BOTTOM;
      cmp_a_act <= CNT_BOTTOM;
      cmp_b_act <= CNT_BOTTOM;
      capture_reg <= CNT_BOTTOM;
      rdata <= CTRL_RST;
      wave_a <= 1'b0;
      wave_b <= 1'b0;
      irq <= 1'b0;
    end else begin
      ctrl_reg_a <= next_ctrl_a;
      ctrl_reg_b <= next_ctrl_b;
      timer_flag_reg <= next_flag;
      timer_mask_reg <= next_mask;
      hold_hi <= next_hold;
      count_value <= next_count;
      compare_reg_a <= next_cmpa;
      compare_reg_b <= next_cmpb;
      cmp_a_act <= next_cmpa_act;
      cmp_b_act <= next_cmpb_act;
      capture_reg <= next_cap;
      rdata <= next_rdata;
      wave_a <= next_wave_a;
      wave_b <= next_wave_b;
      irq <= next_irq;
    end
  end

  assign rdata_o = rdata;
  assign wave_out_a_o = wave_a;
  assign wave_out_b_o = wave_b;
  assign irq_o = irq;

  // low write loads holding byte and data together
  low_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    hit(req_i.wr, req_i.addr, ADDR_CMPA_L) |=> compare_reg_a == {$past(hold_hi), $past(req_i.wdata)})
    else $error("compare a low write did not merge holding byte");
  // high write alone changes no 16-bit register
  high_only_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    hit(req_i.wr, req_i.addr, ADDR_CMPB_H) |=> $stable(compare_reg_b) && hold_hi == $past(req_i.wdata))
    else $error("high write touched a 16-bit register");
  // low read snapshots high byte
  low_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    hit(req_i.rd, req_i.addr, ADDR_CNT_L) |=> hold_hi == $past(count_value[15:8]))
    else $error("low read did not snapshot high byte");
  // compare high read bypasses holding register
  cmp_hi_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    hit(req_i.rd, req_i.addr, ADDR_CMPA_H) |=> rdata_o == $past(compare_reg_a[15:8]) && $stable(hold_hi))
    else $error("compare high read used holding register");
  // counter high location reads holding register
  cnt_hi_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    hit(req_i.rd, req_i.addr, ADDR_CNT_H) |=> rdata_o == $past(hold_hi))
    else $error("counter high read not from holding register");
  // counter write wins over counting
  cnt_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    hit(req_i.wr, req_i.addr, ADDR_CNT_L) |=> count_value == {$past(hold_hi), $past(req_i.wdata)})
    else $error("counter write lost to count");
  // stopped clock keeps the count
  stop_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ctrl_reg_b[2:0] == CS_STOP && $past(ctrl_reg_b[2:0]) == CS_STOP && !req_i.wr)
    |=> $stable(count_value))
    else $error("counter moved with no clock source");
  // capture event latches count and flags
  capture_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    cap_evt |=> capture_reg == $past(count_value) && timer_flag_reg[FLG_CAP])
    else $error("capture did not latch the count");
  // compare match sets flag
  match_flag_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    tick && match_a |=> timer_flag_reg[FLG_CMPA])
    else $error("compare match a flag not set");
  // interrupt follows masked flags
  irq_mask_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    irq_o == |(timer_flag_reg & timer_mask_reg))
    else $error("interrupt not equal masked flags");
  // a wrap at top lands on bottom unless the counter low byte is written in that cycle
  wrap_bottom_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    tick && at_top && !hit(req_i.wr, req_i.addr, ADDR_CNT_L) |=> at_bottom)
    else $error("wrap at top did not land on bottom");
  // in normal mode a tick at max raises the overflow flag
  max_ovf_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    tick && at_max && mode == 4'h0 |=> timer_flag_reg[FLG_OVF])
    else $error("tick at max did not raise overflow");
endmodule

/* File: sim/tmw_cpu_model.sv */
/*
  tmw_cpu_model: behavioural cpu on the 8-bit register port of the timer.
  assumes one caller at a time, so no interrupt code can cut into a pair.
*/
`timescale 1ns/1ps
module tmw_cpu_model (
  // clock
  input wire logic sys_clk_i,
  // register port
  output tmw_pkg::tmw_req_s req_o,
  input wire logic [7:0] rdata_i
);
  import tmw_pkg::*;

  // idle port at time zero, nothing strobed
  initial begin
    req_o = '0;
  end

  // one-cycle write strobe, released on the following edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_i);
    req_o <= '0;
  endtask

  // read data only stand in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    req_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_i);
    req_o <= '0;
    #1;
    d = rdata_i;
  endtask

  // word write: high location first, low location moves the word
  task automatic wr16(input logic [4:0] lo, input logic [15:0] v);
    wr(lo + 5'h01, v[15:8]);
    wr(lo, v[7:0]);
  endtask

  // word read: low first latches the high byte for the second read
  task automatic rd16(input logic [4:0] lo, output logic [15:0] v);
    rd(lo, v[7:0]);
    rd(lo + 5'h01, v[15:8]);
  endtask
endmodule

/* File: sim/tmw_timer16_tb.sv */
/*
  tmw_timer16_tb: self-checking bench for the 16-bit timer block.
  assumes the cpu model drives the register port and the bench owns the pins.
*/
`timescale 1ns/1ps
module tmw_timer16_tb;
  import tmw_pkg::*;

  logic sys_clk, rst, pwr_off, ext_pin, cap_pin, comp, from_comp;
  logic wave_a, wave_b, irq;
  logic [7:0] rdata;
  tmw_req_s req;
  int error_cnt = 0;
  int checks_done = 0;

  // device under test and the cpu facing it
  tmw_timer16 dut (.sys_clk_i(sys_clk), .rst_i(rst), .req_i(req), .rdata_o(rdata),
    .timer_power_off_bit_i(pwr_off), .ext_count_pin_i(ext_pin),
    .capture_pin_i(cap_pin), .comparator_i(comp), .cap_from_comp_i(from_comp),
    .wave_out_a_o(wave_a), .wave_out_b_o(wave_b), .irq_o(irq));
  tmw_cpu_model cpu (.sys_clk_i(sys_clk), .req_o(req), .rdata_i(rdata));

  // free-running 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // verdict in one place
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // compare tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    chk8(got[15:8], exp[15:8]);
    chk8(got[7:0], exp[7:0]);
  endtask

  // reset state and unmapped space
  task automatic t_reset();
    logic [7:0] d;
    chk8({5'h00, irq, wave_a, wave_b}, 8'h00);
    cpu.rd(ADDR_CTRL_A, d); chk8(d, CTRL_RST);
    cpu.rd(ADDR_CTRL_B, d); chk8(d, CTRL_RST);
    cpu.rd(ADDR_MASK, d); chk8(d, 8'h00);
    cpu.rd(5'h1f, d); chk8(d, 8'h00);
  endtask

  // word transfers and the shared holding byte, clock stopped
  task automatic t_words();
    logic [15:0] v;
    logic [7:0] d;
    cpu.wr16(ADDR_CNT_L, 16'h01ff);
    cpu.rd16(ADDR_CNT_L, v); chk16(v, 16'h01ff);
    cpu.wr(ADDR_CNT_H, 8'haa);
    cpu.rd16(ADDR_CNT_L, v); chk16(v, 16'h01ff);
    cpu.wr(ADDR_CMPA_H, 8'h12);
    cpu.wr(ADDR_CMPA_L, 8'h34);
    cpu.wr(ADDR_CMPB_L, 8'h56);
    cpu.rd(ADDR_CNT_L, d);
    cpu.rd(ADDR_CMPA_H, d); chk8(d, 8'h12);
    cpu.rd(ADDR_CMPB_H, d); chk8(d, 8'h12);
    cpu.rd(ADDR_CMPA_L, d); chk8(d, 8'h34);
    cpu.rd(ADDR_CMPB_L, d); chk8(d, 8'h56);
    cpu.rd(ADDR_CNT_H, d); chk8(d, 8'h01);
  endtask

  // power-off holds the count; then wrap with two matches and an interrupt
  task automatic t_count();
    logic [15:0] v;
    logic [7:0] d;
    cpu.wr16(ADDR_CMPA_L, 16'hfff8);
    cpu.wr16(ADDR_CMPB_L, 16'h0004);
    cpu.wr16(ADDR_CNT_L, 16'hfff0);
    cpu.wr(ADDR_CTRL_B, 8'h01);
    repeat (20) @(posedge sys_clk);
    cpu.rd16(ADDR_CNT_L, v); chk16(v, 16'hfff0);
    pwr_off <= 1'b0;
    repeat (30) @(posedge sys_clk);
    cpu.wr(ADDR_CTRL_B, {5'h00, CS_STOP});
    cpu.rd(ADDR_FLAG, d); chk8(d, 8'h07);
    chk8({6'h00, wave_a, wave_b}, 8'h03);
    cpu.wr(ADDR_MASK, 8'h02);
    repeat (2) @(posedge sys_clk);
    chk8({7'h00, irq}, 8'h01);
    cpu.wr(ADDR_FLAG, 8'h07);
    cpu.rd(ADDR_FLAG, d); chk8(d, 8'h00);
    @(posedge sys_clk);
    chk8({7'h00, irq}, 8'h00);
  endtask

  // pin clock on either edge, five pulses each
  task automatic t_ext(input logic [2:0] cs, input logic [15:0] exp);
    logic [15:0] v;
    cpu.wr(ADDR_CTRL_B, {5'h00, cs});
    repeat (5) begin
      @(posedge sys_clk);
      ext_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ext_pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    repeat (6) @(posedge sys_clk);
    cpu.wr(ADDR_CTRL_B, {5'h00, CS_STOP});
    cpu.rd16(ADDR_CNT_L, v); chk16(v, exp);
  endtask

  // divide-by-8 tap: ten or eleven ticks in the window, prescaler phase unknown
  task automatic t_presc();
    logic [15:0] v;
    cpu.wr16(ADDR_CNT_L, 16'h0000);
    cpu.wr(ADDR_CTRL_B, 8'h02);
    repeat (80) @(posedge sys_clk);
    cpu.wr(ADDR_CTRL_B, {5'h00, CS_STOP});
    cpu.rd16(ADDR_CNT_L, v);
    chk8({7'h00, v >= 16'h0009 && v <= 16'h000b}, 8'h01);
  endtask

  // eight-bit fixed top: six ticks from 0x00fc wrap to 0x0002, not 0x0102
  task automatic t_top();
    logic [15:0] v;
    logic [7:0] d;
    cpu.wr(ADDR_CTRL_A, 8'h01);
    cpu.wr16(ADDR_CNT_L, 16'h00fc);
    cpu.wr(ADDR_FLAG, 8'h01);
    cpu.wr(ADDR_CTRL_B, 8'h01);
    repeat (4) @(posedge sys_clk);
    cpu.wr(ADDR_CTRL_B, {5'h00, CS_STOP});
    cpu.rd16(ADDR_CNT_L, v); chk16(v, 16'h0002);
    cpu.rd(ADDR_FLAG, d); chk8(d & 8'h01, 8'h01);
    cpu.wr(ADDR_CTRL_A, 8'h00);
  endtask

  // filtered capture: a two-cycle glitch is ignored, a steady level is taken
  task automatic t_filter();
    logic [15:0] v;
    logic [7:0] d;
    from_comp <= 1'b0;
    cpu.wr(ADDR_CTRL_B, 8'hc0);
    cpu.wr(ADDR_FLAG, 8'h20);
    cpu.wr16(ADDR_CNT_L, 16'h0abc);
    cap_pin <= 1'b1;
    repeat (2) @(posedge sys_clk);
    cap_pin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    cpu.rd(ADDR_FLAG, d); chk8(d & 8'h20, 8'h00);
    cpu.wr16(ADDR_CNT_L, 16'h0def);
    cap_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    cap_pin <= 1'b0;
    cpu.rd16(ADDR_CAP_L, v); chk16(v, 16'h0def);
    cpu.rd(ADDR_FLAG, d); chk8(d & 8'h20, 8'h20);
  endtask

  // capture from the pin, then from the comparator
  task automatic t_capture(input logic sel, input logic [15:0] cnt);
    logic [15:0] v;
    logic [7:0] d;
    from_comp <= sel;
    cpu.wr(ADDR_FLAG, 8'h20);
    cpu.wr16(ADDR_CNT_L, cnt);
    repeat (8) @(posedge sys_clk);
    if (sel) comp <= 1'b1;
    else cap_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    comp <= 1'b0;
    cap_pin <= 1'b0;
    cpu.rd16(ADDR_CAP_L, v); chk16(v, cnt);
    cpu.rd(ADDR_FLAG, d); chk8(d & 8'h20, 8'h20);
  endtask

  // force bits sit in ctrl_c and read back as zero
  task automatic t_force();
    logic old_a;
    logic old_b;
    logic [7:0] d;
    old_a = wave_a;
    old_b = wave_b;
    cpu.wr(ADDR_CTRL_C, 8'h80);
    repeat (2) @(posedge sys_clk);
    chk8({7'h00, wave_a}, {7'h00, ~old_a});
    cpu.wr(ADDR_CTRL_C, 8'h40);
    repeat (2) @(posedge sys_clk);
    chk8({7'h00, wave_b}, {7'h00, ~old_b});
    cpu.rd(ADDR_CTRL_C, d); chk8(d, 8'h00);
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    pwr_off = 1'b1;
    ext_pin = 1'b0;
    cap_pin = 1'b0;
    comp = 1'b0;
    from_comp = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_words();
    t_count();
    cpu.wr16(ADDR_CNT_L, 16'h0100);
    t_ext(CS_EXT_RISE, 16'h0105);
    t_ext(CS_EXT_FALL, 16'h010a);
    t_presc();
    t_top();
    cpu.wr(ADDR_CTRL_B, 8'h40);
    t_capture(1'b0, 16'h2468);
    t_capture(1'b1, 16'h1357);
    t_filter();
    t_force();
    test_done();
  end

  // watchdog well past the few hundred cycles the tests need
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
endmodule
